// file: src/apcfg_pkg.sv
// Package for the analog PLL configuration register bank
package apcfg_pkg;
   // Word byte addresses on the bus
   localparam logic [3:0] ADDR_FRAC = 4'h0;
   localparam logic [3:0] ADDR_INT = 4'h4;
   localparam logic [3:0] ADDR_MOD = 4'h8;
   localparam logic [3:0] ADDR_DBL = 4'hC;
   localparam logic [4:0] ADDR_PUMP = 5'h10;
   localparam int ADDR_W = 5;

   // Field widths and positions
   localparam int FRAC_W = 27;
   localparam int INT_W = 10;
   localparam int FRAC_DENOM_LOG2 = 27;
   localparam int MOD_DITHER_ON_BIT = 5;
   localparam int MOD_SHAPING_BIT = 4;
   localparam int MOD_SCALE_LSB = 2;
   localparam int MOD_ORDER_LSB = 0;
   localparam int DBL_SEL_BIT = 1;
   localparam int DBL_EN_BIT = 0;
   localparam int PUMP_OFS_ON_BIT = 13;
   localparam int PUMP_RANGE_BIT = 12;
   localparam int PUMP_OFS_LSB = 8;
   localparam int PUMP_UP_LSB = 4;
   localparam int PUMP_DN_LSB = 0;

   // Reset values
   localparam logic [9:0] INT_RST = 10'h069;
   localparam logic [1:0] ORDER_RST = 2'h3;
   localparam logic [3:0] OFS_RST = 4'h3;
   localparam logic [2:0] UP_RST = 3'h3;
   localparam logic [2:0] DN_RST = 3'h3;

   typedef enum logic [1:0] {
      APCFG_ORD_INTEGER,
      APCFG_ORD_FIRST,
      APCFG_ORD_SECOND,
      APCFG_ORD_THIRD
   } apcfg_order_t;

   typedef struct packed {
      logic [26:0] frac;
      logic [9:0] integ;
      logic dither_on;
      logic shaping;
      logic [1:0] scale;
      apcfg_order_t order;
      logic dbl_sel;
      logic dbl_en;
      logic ofs_on;
      logic range_high;
      logic [3:0] ofs_level;
      logic [2:0] up_level;
      logic [2:0] dn_level;
   } apcfg_fields_t;

   // Decoded settings that reach the analog macro
   typedef struct packed {
      logic [26:0] fb_fraction_numerator;
      logic [9:0] fb_integer_ratio;
      logic modulator_active;
      apcfg_order_t modulator_order_select;
      logic modulator_dither_on;
      logic modulator_dither_shaping;
      logic [3:0] dither_amplitude;
      logic pll_doubler_on;
      logic pfd_doubler_on;
      logic pump_offset_on;
      logic pump_offset_range_high;
      logic [3:0] pump_offset_level;
      logic [2:0] pump_up_level;
      logic [2:0] pump_down_level;
   } apcfg_ctrl_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [4:0] adr;
      logic [31:0] dat;
   } apcfg_wb_req_t;
endpackage

// file: src/apcfg_decode.sv
// Registered decode of stored fields into analog control settings
`timescale 1ns/1ns
module apcfg_decode (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Stored fields
   input apcfg_pkg::apcfg_fields_t fields_i,
   // Settings to the PLL
   output apcfg_pkg::apcfg_ctrl_t ctrl_o
);
   typedef struct packed {
      apcfg_pkg::apcfg_ctrl_t ctrl;
   } apcfg_dec_state_t;

   apcfg_dec_state_t state_reg;
   apcfg_dec_state_t state_next;

   always_comb begin
      state_next = state_reg;
      state_next.ctrl.fb_fraction_numerator = fields_i.frac;
      state_next.ctrl.fb_integer_ratio = fields_i.integ;
      state_next.ctrl.modulator_order_select = fields_i.order;
      // Order zero bypasses the modulator entirely
      state_next.ctrl.modulator_active =
         (fields_i.order != apcfg_pkg::APCFG_ORD_INTEGER);
      state_next.ctrl.modulator_dither_on = fields_i.dither_on;
      state_next.ctrl.modulator_dither_shaping = fields_i.shaping;
      // One-hot amplitude: 1, 2, 4 or 8 LSB
      state_next.ctrl.dither_amplitude = 4'h1 << fields_i.scale;
      state_next.ctrl.pll_doubler_on =
         fields_i.dbl_en & ~fields_i.dbl_sel;
      state_next.ctrl.pfd_doubler_on =
         fields_i.dbl_en & fields_i.dbl_sel;
      state_next.ctrl.pump_offset_on = fields_i.ofs_on;
      state_next.ctrl.pump_offset_range_high = fields_i.range_high;
      // No offset current unless enabled
      state_next.ctrl.pump_offset_level =
         fields_i.ofs_on ? fields_i.ofs_level : 4'h0;
      state_next.ctrl.pump_up_level = fields_i.up_level;
      state_next.ctrl.pump_down_level = fields_i.dn_level;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign ctrl_o = state_reg.ctrl;
endmodule

// file: src/apcfg_bank.sv
// Wishbone register bank for analog PLL divider and pump settings
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// Function
// - Hold 27-bit fraction numerator over fixed denominator two to 27th.
// - Hold 10-bit integer divide ratio, reset 0x69.
// - Two-bit modulator order: integer, first, second, third; reset third.
// - Bit five turns dither on; reset off.
// - Bit four selects shaped dither; reset unshaped.
// - Dither scale codes give one, two, four, eight LSB; reset one.
// - Doubler select: clear PLL side, set PFD side, only when enabled.
// - Bit zero enables selected doubler; reset enabled.
// - Bit thirteen enables pump offset current; clear means none.
// - Bit twelve selects high offset current range.
// - Four-bit offset level in bits 11:8, zero none, reset 3.
// - Three-bit up current code in bits 6:4, reset 3.
// - Three-bit down current code in bits 2:0, reset 3.
module apcfg_bank (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Settings to the PLL
   output apcfg_pkg::apcfg_ctrl_t ctrl_o,
   // Software misuse flag: fraction nonzero with order zero
   output logic order_conflict_o
);
   typedef struct packed {
      apcfg_pkg::apcfg_fields_t f;
      logic [31:0] rdata;
      logic ack;
      logic err;
      logic conflict;
   } apcfg_bank_state_t;

   apcfg_bank_state_t state_reg;
   apcfg_bank_state_t state_next;
   apcfg_pkg::apcfg_wb_req_t req;
   logic [31:0] wmask;
   logic [31:0] rd_word;
   logic hit;
   logic [31:0] frac_w;
   logic [31:0] int_w;
   logic [31:0] mod_w;
   logic [31:0] dbl_w;
   logic [31:0] pump_w;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                  sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

   // Register images, reserved bits forced to zero
   always_comb begin
      frac_w = 32'h0;
      frac_w[apcfg_pkg::FRAC_W-1:0] = state_reg.f.frac;
      int_w = 32'h0;
      int_w[apcfg_pkg::INT_W-1:0] = state_reg.f.integ;
      mod_w = 32'h0;
      mod_w[apcfg_pkg::MOD_DITHER_ON_BIT] = state_reg.f.dither_on;
      mod_w[apcfg_pkg::MOD_SHAPING_BIT] = state_reg.f.shaping;
      mod_w[apcfg_pkg::MOD_SCALE_LSB +: 2] = state_reg.f.scale;
      mod_w[apcfg_pkg::MOD_ORDER_LSB +: 2] = state_reg.f.order;
      dbl_w = 32'h0;
      dbl_w[apcfg_pkg::DBL_SEL_BIT] = state_reg.f.dbl_sel;
      dbl_w[apcfg_pkg::DBL_EN_BIT] = state_reg.f.dbl_en;
      pump_w = 32'h0;
      pump_w[apcfg_pkg::PUMP_OFS_ON_BIT] = state_reg.f.ofs_on;
      pump_w[apcfg_pkg::PUMP_RANGE_BIT] = state_reg.f.range_high;
      pump_w[apcfg_pkg::PUMP_OFS_LSB +: 4] = state_reg.f.ofs_level;
      pump_w[apcfg_pkg::PUMP_UP_LSB +: 3] = state_reg.f.up_level;
      pump_w[apcfg_pkg::PUMP_DN_LSB +: 3] = state_reg.f.dn_level;
   end

   // Byte-lane mask from sel
   always_comb begin
      wmask = {{8{req.sel[3]}}, {8{req.sel[2]}},
               {8{req.sel[1]}}, {8{req.sel[0]}}};
   end

   always_comb begin
      hit = 1'b1;
      rd_word = 32'h0;
      unique case (req.adr)
         {1'b0, apcfg_pkg::ADDR_FRAC}: rd_word = frac_w;
         {1'b0, apcfg_pkg::ADDR_INT}: rd_word = int_w;
         {1'b0, apcfg_pkg::ADDR_MOD}: rd_word = mod_w;
         {1'b0, apcfg_pkg::ADDR_DBL}: rd_word = dbl_w;
         apcfg_pkg::ADDR_PUMP: rd_word = pump_w;
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      logic [31:0] nw;
      nw = 32'h0;
      state_next = state_reg;
      state_next.ack = 1'b0;
      state_next.err = 1'b0;
      // One wait state; ack drops the cycle after it is given
      if (req.cyc && req.stb && !state_reg.ack && !state_reg.err) begin
         state_next.ack = hit;
         state_next.err = ~hit;
         state_next.rdata = hit ? rd_word : 32'h0;
         if (req.we && hit) begin
            nw = (rd_word & ~wmask) | (req.dat & wmask);
            // Only defined fields are taken; reserved bits dropped
            unique case (req.adr)
               {1'b0, apcfg_pkg::ADDR_FRAC}: begin
                  state_next.f.frac = nw[apcfg_pkg::FRAC_W-1:0];
               end
               {1'b0, apcfg_pkg::ADDR_INT}: begin
                  state_next.f.integ = nw[apcfg_pkg::INT_W-1:0];
               end
               {1'b0, apcfg_pkg::ADDR_MOD}: begin
                  state_next.f.dither_on =
                     nw[apcfg_pkg::MOD_DITHER_ON_BIT];
                  state_next.f.shaping =
                     nw[apcfg_pkg::MOD_SHAPING_BIT];
                  state_next.f.scale =
                     nw[apcfg_pkg::MOD_SCALE_LSB +: 2];
                  state_next.f.order = apcfg_pkg::apcfg_order_t'(
                     nw[apcfg_pkg::MOD_ORDER_LSB +: 2]);
               end
               {1'b0, apcfg_pkg::ADDR_DBL}: begin
                  state_next.f.dbl_sel = nw[apcfg_pkg::DBL_SEL_BIT];
                  state_next.f.dbl_en = nw[apcfg_pkg::DBL_EN_BIT];
               end
               apcfg_pkg::ADDR_PUMP: begin
                  state_next.f.ofs_on =
                     nw[apcfg_pkg::PUMP_OFS_ON_BIT];
                  state_next.f.range_high =
                     nw[apcfg_pkg::PUMP_RANGE_BIT];
                  state_next.f.ofs_level =
                     nw[apcfg_pkg::PUMP_OFS_LSB +: 4];
                  state_next.f.up_level =
                     nw[apcfg_pkg::PUMP_UP_LSB +: 3];
                  state_next.f.dn_level =
                     nw[apcfg_pkg::PUMP_DN_LSB +: 3];
               end
               default: begin
               end
            endcase
         end
      end
      // Flag software programming a fraction with the modulator off
      state_next.conflict = (state_reg.f.frac != '0) &&
         (state_reg.f.order == apcfg_pkg::APCFG_ORD_INTEGER);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
         state_reg.f.integ <= apcfg_pkg::INT_RST;
         state_reg.f.order <= apcfg_pkg::apcfg_order_t'(
            apcfg_pkg::ORDER_RST);
         state_reg.f.dbl_en <= 1'b1;
         state_reg.f.ofs_level <= apcfg_pkg::OFS_RST;
         state_reg.f.up_level <= apcfg_pkg::UP_RST;
         state_reg.f.dn_level <= apcfg_pkg::DN_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   apcfg_decode u_decode (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .fields_i(state_reg.f),
      .ctrl_o(ctrl_o)
   );

   assign wb_dat_o = state_reg.rdata;
   assign wb_ack_o = state_reg.ack;
   assign wb_err_o = state_reg.err;
   assign order_conflict_o = state_reg.conflict;
endmodule

// file: bench/apcfg_chk.sv
// Bus and decode assertions for the PLL configuration bank
`timescale 1ns/1ns
module apcfg_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // Settings
   input apcfg_pkg::apcfg_ctrl_t ctrl_o,
   input wire logic order_conflict_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic take;
   logic hit;
   logic wr;
   assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign hit = wb_adr_i inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};
   assign wr = take & wb_we_i & (wb_sel_i == 4'hF);
   a_bus_answer: assert property (take && hit |=> wb_ack_o && !wb_err_o)
      else $error("mapped request not acked");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_err_unmapped: assert property (
      take && !hit |=> wb_err_o && wb_dat_o == 32'h0)
      else $error("unmapped access not refused");
   a_frac_write: assert property (
      wr && wb_adr_i == 5'h00 |-> ##2
      ctrl_o.fb_fraction_numerator == $past(wb_dat_i[26:0], 2))
      else $error("fraction not applied");
   a_int_write: assert property (
      wr && wb_adr_i == 5'h04 |-> ##2
      ctrl_o.fb_integer_ratio == $past(wb_dat_i[9:0], 2))
      else $error("integer ratio not applied");
   a_dither_scale: assert property (
      wr && wb_adr_i == 5'h08 |-> ##2
      ctrl_o.dither_amplitude == (4'h1 << $past(wb_dat_i[3:2], 2)))
      else $error("dither amplitude wrong");
   a_doubler_split: assert property (
      wr && wb_adr_i == 5'h0C |-> ##2
      ctrl_o.pfd_doubler_on == &$past(wb_dat_i[1:0], 2))
      else $error("doubler select wrong");
   a_offset_gate: assert property (
      wr && wb_adr_i == 5'h10 |-> ##2
      ctrl_o.pump_offset_level == ($past(wb_dat_i[13], 2) ?
         $past(wb_dat_i[11:8], 2) : 4'h0))
      else $error("offset level not gated");
   a_mod_active: assert property (
      ctrl_o.modulator_active == (ctrl_o.modulator_order_select !=
         apcfg_pkg::APCFG_ORD_INTEGER))
      else $error("modulator active mismatch");
   a_conflict_flag: assert property (
      order_conflict_o == (ctrl_o.fb_fraction_numerator != 27'h0 &&
         ctrl_o.modulator_order_select == apcfg_pkg::APCFG_ORD_INTEGER))
      else $error("order conflict flag wrong");
   c_unmapped: cover property (take && !hit);
   c_pfd: cover property (ctrl_o.pfd_doubler_on);
   c_conflict: cover property (order_conflict_o);
endmodule
bind apcfg_bank apcfg_chk apcfg_chk_i (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .ctrl_o(ctrl_o), .order_conflict_o(order_conflict_o));

// file: bench/tb_top.sv
// Directed bus test of the PLL configuration bank
`timescale 1ns/1ns
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [4:0] wb_adr_i = 5'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic wb_err_o;
   apcfg_pkg::apcfg_ctrl_t ctrl_o;
   logic order_conflict_o;
   int n_errors = 0;
   int comparisons = 0;
   logic [31:0] rd;
   logic rd_err;
   logic [31:0] pv;
   logic [4:0] adr_t [5] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};
   logic [31:0] msk_t [5] = '{32'h07FFFFFF, 32'h3FF, 32'h3F, 32'h3, 32'h3F77};
   logic [31:0] pv_t [2] = '{32'h1A57, 32'h2F57};
   apcfg_bank apcfg_bank_i (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .ctrl_o(ctrl_o), .order_conflict_o(order_conflict_o));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // Leading edge keeps a one-cycle gap between transfers
   task automatic bus(input logic we, input logic [4:0] a,
         input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do
         @(posedge clk_i);
      while ((wb_ack_o | wb_err_o) !== 1'b1);
      rd = wb_dat_o;
      rd_err = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      // Decode and flag register at the ack edge; compare once settled
      @(negedge clk_i);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hF);
      chk("readback", rd, e);
   endtask
   task automatic results();
      $display("Comparisons %0d, errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(5'h00, 32'h0);
      rdchk(5'h04, 32'h69);
      rdchk(5'h08, 32'h03);
      rdchk(5'h0C, 32'h01);
      rdchk(5'h10, 32'h0333);
      chk("reset pump",
         32'({ctrl_o.pump_offset_level, ctrl_o.pll_doubler_on}), 32'h1);
      foreach (adr_t[i]) begin
         bus(1'b1, adr_t[i], 32'hFFFFFFFF, 4'hF);
         rdchk(adr_t[i], msk_t[i]);
      end
      // Only byte lane one is written
      bus(1'b1, 5'h04, 32'h0, 4'h2);
      chk("int", 32'(ctrl_o.fb_integer_ratio), 32'h0FF);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 5'h08, 32'({i[1], i[0], i[1:0], i[1:0]}), 4'hF);
         chk("mod",
            32'({ctrl_o.modulator_active, ctrl_o.modulator_order_select,
               ctrl_o.modulator_dither_on, ctrl_o.modulator_dither_shaping,
               ctrl_o.dither_amplitude}),
            32'({i != 0, i[1:0], i[1], i[0], 4'h1 << i}));
         bus(1'b1, 5'h0C, 32'(i), 4'hF);
         chk("dbl",
            32'({ctrl_o.pll_doubler_on, ctrl_o.pfd_doubler_on}),
            32'({i == 1, i == 3}));
      end
      foreach (pv_t[i]) begin
         pv = pv_t[i];
         bus(1'b1, 5'h10, pv, 4'hF);
         chk("pump",
            32'({ctrl_o.pump_offset_on, ctrl_o.pump_offset_range_high,
               ctrl_o.pump_offset_level, ctrl_o.pump_up_level,
               ctrl_o.pump_down_level}),
            32'({pv[13], pv[12], pv[13] ? pv[11:8] : 4'h0, pv[6:4],
               pv[2:0]}));
      end
      // Fraction still all ones, so integer order is a misuse
      bus(1'b1, 5'h08, 32'h0, 4'hF);
      chk("conflict", 32'(order_conflict_o), 32'h1);
      bus(1'b1, 5'h00, 32'h05A5A5A5, 4'hF);
      chk("frac", 32'(ctrl_o.fb_fraction_numerator), 32'h05A5A5A5);
      bus(1'b1, 5'h00, 32'h0, 4'hF);
      chk("conflict", 32'(order_conflict_o), 32'h0);
      bus(1'b0, 5'h14, 32'h0, 4'hF);
      chk("unmapped", {rd_err, rd[30:0]}, 32'h80000000);
      results();
   end
   initial begin
      #100000;
      n_errors++;
      results();
   end
endmodule
